// ### verilog/idw_pkg.sv
// Shared constants, layouts and types of the deactivate-interrupt block
package idw_pkg;
    // ==========================================================
    // Written-word layout
    localparam int ID_W = 10;
    localparam int CPU_W = 3;
    localparam int CPU_LSB = 10;
    localparam logic [9:0] SPURIOUS_ID = 10'h3ff;
    localparam logic [9:0] SWINT_LAST_ID = 10'h00f;
    localparam int NUM_INT_DEF = 64;
    localparam int APR_COUNT = 4;
    localparam int SWINT_WORDS = 4;

    // ==========================================================
    // Register offsets (byte addresses, 4 KiB window)
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_DEACT = 12'h004;
    localparam logic [11:0] OFF_LAST = 12'h008;
    localparam logic [11:0] OFF_GROUP = 12'h080;
    localparam logic [11:0] OFF_SET_ACT = 12'h100;
    localparam logic [11:0] OFF_CLR_ACT = 12'h180;
    localparam logic [11:0] OFF_SET_SWINT = 12'h200;
    localparam logic [11:0] OFF_CLR_SWINT = 12'h210;
    localparam logic [11:0] OFF_APR = 12'h300;
    localparam logic [11:0] OFF_NSAPR = 12'h310;

    // ==========================================================
    // Control register fields and reset values
    localparam int CTRL_EOI_S_BIT = 0;
    localparam int CTRL_EOI_NS_BIT = 1;
    localparam int CTRL_ACK_BIT = 2;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // ==========================================================
    // Types
    typedef struct packed {
        logic valid;
        logic nonsecure;
        logic [9:0] int_id;
        logic [2:0] src_cpu;
    } idw_dir_req_s;

    typedef struct packed {
        logic nonsec;
        logic [11:0] addr;
    } idw_phase_s;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_READ_WAIT = 4'b0100,
        BUS_READ_DONE = 4'b1000
    } idw_bus_e;
endpackage : idw_pkg

// ### verilog/idw_dir_decode.sv
// Qualifies a deactivate write against split mode, security state and group
`timescale 1ns/1ps
module idw_dir_decode
    import idw_pkg::*;
#(
    parameter int NUM_INT = NUM_INT_DEF,
    parameter bit HAS_SECURITY = 1'b1
) (
    input wire idw_dir_req_s req,
    input wire logic split_eoi_mode_secure,
    input wire logic split_eoi_mode_nonsecure,
    input wire logic target_group1,
    output logic deact_en,
    output logic [9:0] deact_id,
    output logic [2:0] deact_cpu
);
    logic eff_nonsec;
    logic split_ok;
    logic group_ok;
    logic id_ok;

    // Without the security option every write acts as a secure one
    assign eff_nonsec = HAS_SECURITY && req.nonsecure;
    // The secure bit doubles as the plain split mode bit when unsecured
    assign split_ok = eff_nonsec ? split_eoi_mode_nonsecure : split_eoi_mode_secure;
    assign group_ok = !eff_nonsec || target_group1;
    // Spurious and unimplemented identifiers touch nothing
    assign id_ok = (req.int_id != SPURIOUS_ID) && (32'(req.int_id) < NUM_INT);
    // Mode-off writes are undefined; they are dropped here
    assign deact_en = req.valid && split_ok && group_ok && id_ok;
    assign deact_id = req.int_id;
    // Source field only has a meaning for software-generated interrupts
    assign deact_cpu = (req.int_id <= SWINT_LAST_ID) ? req.src_cpu : 3'h0;
endmodule : idw_dir_decode

// ### verilog/idw_active_bank.sv
// Active-state flags, one bit per interrupt, with no hidden state
`timescale 1ns/1ps
module idw_active_bank
    import idw_pkg::*;
#(
    parameter int NUM_INT = NUM_INT_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NUM_INT-1:0] set_vec,
    input wire logic [NUM_INT-1:0] clr_vec,
    input wire logic deact_en,
    input wire logic [9:0] deact_id,
    output logic [NUM_INT-1:0] active
);
    // ==========================================================
    // Per-interrupt flag; the bit is the whole state, so a save of
    // the set-active view followed by a write back restores it
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INT; gi++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    active[gi] <= 1'b0;
                end else if (clr_vec[gi] || (deact_en && deact_id == 10'(gi))) begin
                    active[gi] <= 1'b0;
                end else if (set_vec[gi]) begin
                    active[gi] <= 1'b1;
                end
            end
        end
    endgenerate
endmodule : idw_active_bank

// ### verilog/idw_deactivate.sv
// AHB-Lite register block: deactivate path and active-state save/restore
// Operation
// - Split-mode deactivate write clears the named interrupt's active flag.
// - Unsecured build: write acts only while split mode bit is one.
// - Secured build: secure or nonsecure split bit, chosen by access, must be one.
// - Deactivate writes are accepted in any order.
// - Word holds identifier in bits 9:0, source processor in 12:10.
// - Source field counts only for software-generated interrupts, else zero.
// - Acknowledge-control bit has no effect on deactivation.
// - Unsecured build deactivates any group, like a secure write.
// - Secure write deactivates any group; nonsecure only group 1.
// - Set-active and clear-active arrays read and rewrite active state.
// - Saved set-active bits restore all active state.
// - Software-generated pending bits set and cleared individually.
// - Active-priority words of both groups are readable and writable.
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module idw_deactivate
    import idw_pkg::*;
#(
    parameter int NUM_INT = NUM_INT_DEF,
    parameter bit HAS_SECURITY = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hnonsec,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [NUM_INT-1:0] int_active,
    output logic [NUM_INT-1:0] int_group1,
    output logic [127:0] swint_pending,
    output logic ack_control
);
    localparam int NW = (NUM_INT + 31) / 32;

    // ==========================================================
    // Bus state
    idw_bus_e bus_reg;
    idw_bus_e bus_next;
    idw_phase_s phase_reg;
    logic accept;
    logic wr_en;
    logic eff_nonsec;

    // Only whole-word single transfers are expected; size is not checked
    assign accept = hsel && hready && htrans[1];
    assign hreadyout = (bus_reg != BUS_READ_WAIT);
    assign hresp = 1'b0;

    always_comb begin
        bus_next = BUS_IDLE;
        if (accept) begin
            bus_next = hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end else if (bus_reg == BUS_READ_WAIT) begin
            bus_next = BUS_READ_DONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg <= BUS_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= '0;
        end else if (accept) begin
            phase_reg.nonsec <= hnonsec && HAS_SECURITY;
            phase_reg.addr <= {haddr[11:2], 2'b00};
        end
    end

    assign wr_en = (bus_reg == BUS_WRITE);
    assign eff_nonsec = phase_reg.nonsec;

    // ==========================================================
    // Region decode
    logic hit_ctrl;
    logic hit_deact;
    logic hit_last;
    logic hit_group;
    logic hit_set_act;
    logic hit_clr_act;
    logic hit_set_swint;
    logic hit_clr_swint;
    logic hit_apr;
    logic hit_nsapr;
    logic [4:0] widx;
    logic [1:0] sidx;

    assign hit_ctrl = (phase_reg.addr == OFF_CTRL);
    assign hit_deact = (phase_reg.addr == OFF_DEACT);
    assign hit_last = (phase_reg.addr == OFF_LAST);
    assign hit_group = (phase_reg.addr[11:7] == OFF_GROUP[11:7]);
    assign hit_set_act = (phase_reg.addr[11:7] == OFF_SET_ACT[11:7]);
    assign hit_clr_act = (phase_reg.addr[11:7] == OFF_CLR_ACT[11:7]);
    assign hit_set_swint = (phase_reg.addr[11:4] == OFF_SET_SWINT[11:4]);
    assign hit_clr_swint = (phase_reg.addr[11:4] == OFF_CLR_SWINT[11:4]);
    // Priority words are secure-only in a secured build
    assign hit_apr = (phase_reg.addr[11:4] == OFF_APR[11:4]) && !eff_nonsec;
    assign hit_nsapr = (phase_reg.addr[11:4] == OFF_NSAPR[11:4]) && !eff_nonsec;
    assign widx = phase_reg.addr[6:2];
    assign sidx = phase_reg.addr[3:2];

    // ==========================================================
    // CPU interface control
    logic [31:0] ctrl_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && hit_ctrl) begin
            if (eff_nonsec) begin
                ctrl_reg[CTRL_EOI_NS_BIT] <= hwdata[CTRL_EOI_NS_BIT];
            end else begin
                ctrl_reg <= hwdata & CTRL_MASK;
            end
        end
    end

    // Exported for the acknowledge logic; deactivation never reads it
    assign ack_control = ctrl_reg[CTRL_ACK_BIT];

    // ==========================================================
    // Group configuration, secure-only in a secured build
    logic [NW*32-1:0] group_reg;
    logic [NW*32-1:0] ns_mask;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            group_reg <= '0;
        end else if (wr_en && hit_group && !eff_nonsec && 32'(widx) < NW) begin
            group_reg[widx*32 +: 32] <= hwdata;
        end
    end

    assign int_group1 = group_reg[NUM_INT-1:0];
    // Nonsecure accesses see and change only group 1 bits
    assign ns_mask = eff_nonsec ? group_reg : '1;

    // ==========================================================
    // Deactivate write
    idw_dir_req_s dir_req;
    logic deact_en;
    logic [9:0] deact_id;
    logic [2:0] deact_cpu;
    logic [NW*32-1:0] group_pad;

    assign group_pad = group_reg;
    // Reserved upper bits are ignored; any order of writes is taken
    assign dir_req.valid = wr_en && hit_deact;
    assign dir_req.nonsecure = eff_nonsec;
    assign dir_req.int_id = hwdata[ID_W-1:0];
    assign dir_req.src_cpu = hwdata[CPU_LSB +: CPU_W];

    idw_dir_decode #(
        .NUM_INT(NUM_INT),
        .HAS_SECURITY(HAS_SECURITY)
    ) u_decode (
        .req(dir_req),
        .split_eoi_mode_secure(ctrl_reg[CTRL_EOI_S_BIT]),
        .split_eoi_mode_nonsecure(ctrl_reg[CTRL_EOI_NS_BIT]),
        .target_group1(group_pad[dir_req.int_id[4:0] + 32 * 32'(dir_req.int_id[9:5]) < NW*32 ?
            32'(dir_req.int_id) : 0]),
        .deact_en(deact_en),
        .deact_id(deact_id),
        .deact_cpu(deact_cpu)
    );

    // Last effective deactivation, for software to inspect
    logic [31:0] last_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_reg <= WORD_RESET;
        end else if (deact_en) begin
            last_reg <= {19'h0, deact_cpu, deact_id};
        end
    end

    // ==========================================================
    // Active-state save and restore
    logic [NUM_INT-1:0] set_vec;
    logic [NUM_INT-1:0] clr_vec;

    genvar gw;
    generate
        for (gw = 0; gw < NUM_INT; gw++) begin : g_act
            assign set_vec[gw] = wr_en && hit_set_act && widx == 5'(gw / 32)
                && hwdata[gw % 32] && ns_mask[gw];
            assign clr_vec[gw] = wr_en && hit_clr_act && widx == 5'(gw / 32)
                && hwdata[gw % 32] && ns_mask[gw];
        end
    endgenerate

    idw_active_bank #(
        .NUM_INT(NUM_INT)
    ) u_active (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_vec(set_vec),
        .clr_vec(clr_vec),
        .deact_en(deact_en),
        .deact_id(deact_id),
        .active(int_active)
    );

    // ==========================================================
    // Software-generated pending bits, one per identifier and source pair
    logic [127:0] swint_pend_reg;
    logic [31:0] swint_mask;

    // Each byte belongs to one identifier, so its group bit widens to the byte
    always_comb begin
        swint_mask = '1;
        for (int j = 0; j < 4; j++) begin
            swint_mask[j*8 +: 8] = {8{ns_mask[sidx*4 + j]}};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swint_pend_reg <= '0;
        end else if (wr_en && hit_set_swint) begin
            swint_pend_reg[sidx*32 +: 32] <= swint_pend_reg[sidx*32 +: 32]
                | (hwdata & swint_mask);
        end else if (wr_en && hit_clr_swint) begin
            swint_pend_reg[sidx*32 +: 32] <= swint_pend_reg[sidx*32 +: 32]
                & ~(hwdata & swint_mask);
        end
    end

    assign swint_pending = swint_pend_reg;

    // ==========================================================
    // Active-priority words for both groups
    logic [31:0] apr_reg [APR_COUNT];
    logic [31:0] nsapr_reg [APR_COUNT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < APR_COUNT; i++) begin
                apr_reg[i] <= WORD_RESET;
                nsapr_reg[i] <= WORD_RESET;
            end
        end else if (wr_en && hit_apr) begin
            apr_reg[sidx] <= hwdata;
        end else if (wr_en && hit_nsapr) begin
            nsapr_reg[sidx] <= hwdata;
        end
    end

    // ==========================================================
    // Read data, taken in the first data-phase cycle so that a write
    // just before is already visible; costs one wait state per read
    logic [31:0] rd_word;
    logic [NW*32-1:0] act_word;

    assign act_word = (NW*32)'(int_active) & ns_mask;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_word = eff_nonsec ? (ctrl_reg & (32'h1 << CTRL_EOI_NS_BIT)) : ctrl_reg;
        end else if (hit_last) begin
            rd_word = last_reg;
        end else if ((hit_set_act || hit_clr_act) && 32'(widx) < NW) begin
            rd_word = act_word[widx*32 +: 32];
        end else if (hit_group && !eff_nonsec && 32'(widx) < NW) begin
            rd_word = group_reg[widx*32 +: 32];
        end else if (hit_set_swint || hit_clr_swint) begin
            rd_word = swint_pend_reg[sidx*32 +: 32] & swint_mask;
        end else if (hit_apr) begin
            rd_word = apr_reg[sidx];
        end else if (hit_nsapr) begin
            rd_word = nsapr_reg[sidx];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_RESET;
        end else if (bus_reg == BUS_READ_WAIT) begin
            hrdata <= rd_word;
        end
    end
endmodule : idw_deactivate

// ### tb/idw_deactivate_assertions.sv
// Concurrent checks on the deactivate block's ports
`timescale 1ns/1ps
module idw_deactivate_assertions
    import idw_pkg::*;
#(
    parameter int NUM_INT = NUM_INT_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hnonsec,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_INT-1:0] int_active,
    input wire logic [NUM_INT-1:0] int_group1,
    input wire logic ack_control
);
    // ==========
    // Shadow of the write data phase and the split bits
    logic wp_reg;
    logic wn_reg;
    logic [11:0] wa_reg;
    logic [1:0] ctl_reg;
    wire take = hsel && hready && htrans[1];
    wire dw = wp_reg && hready && wa_reg == OFF_DEACT;
    wire wsec = wp_reg && hready && !wn_reg;
    wire [9:0] id = hwdata[9:0];
    wire split = wn_reg ? ctl_reg[1] : ctl_reg[0];
    wire ok = dw && split && id < NUM_INT && (!wn_reg || int_group1[id]);
    wire [NUM_INT-1:0] wmask = NUM_INT'(hwdata) << (wa_reg[2] ? 32 : 0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_reg <= 1'b0;
            ctl_reg <= 2'b00;
        end else if (hready) begin
            wp_reg <= take && hwrite;
            if (wp_reg && wa_reg == OFF_CTRL) begin
                ctl_reg <= wn_reg ? {hwdata[1], ctl_reg[0]} : hwdata[1:0];
            end
        end
    end
    always_ff @(posedge hclk) begin
        if (take) begin
            wa_reg <= haddr[11:0];
            wn_reg <= hnonsec;
        end
    end
    // ==========
    // Assertions
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_deact_clears: assert property (ok |=> !int_active[$past(id)])
        else $error("interrupt still active after deactivate");
    a_split_zero: assert property (dw && !split |=> $stable(int_active))
        else $error("deactivate acted with split bit clear");
    a_ns_group0: assert property (dw && wn_reg && split && id < NUM_INT && !int_group1[id] |=> $stable(int_active))
        else $error("nonsecure write changed group 0 state");
    a_spurious_quiet: assert property (dw && id == SPURIOUS_ID |=> $stable(int_active) && !hresp)
        else $error("spurious deactivate changed state");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_set_marks: assert property (wsec && wa_reg[11:3] == OFF_SET_ACT[11:3] |=> (int_active & $past(wmask)) == $past(wmask))
        else $error("set-active bit not set");
    a_clr_marks: assert property (wsec && wa_reg[11:3] == OFF_CLR_ACT[11:3] |=> (int_active & $past(wmask)) == '0)
        else $error("clear-active bit not cleared");
    a_ack_copy: assert property (wsec && wa_reg == OFF_CTRL |=> ack_control == $past(hwdata[2]))
        else $error("ack control bit not stored");
endmodule : idw_deactivate_assertions

bind idw_deactivate idw_deactivate_assertions #(.NUM_INT(NUM_INT)) i_idw_deactivate_assertions (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hnonsec(hnonsec), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .int_active(int_active), .int_group1(int_group1), .ack_control(ack_control)
);

// ### tb/idw_sw_master.sv
// Software side: bus master issuing single word transfers
`timescale 1ns/1ps
module idw_sw_master
    import idw_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic hnonsec,
    output logic [31:0] hwdata,
    output logic hung
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hnonsec = 1'b0;
        hwdata = 32'h0;
        hung = 1'b0;
    end
    // ==========
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic ns);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hnonsec <= ns;
        do @(posedge hclk); while (!hready && ++n < 64);
        htrans <= 2'b00;
        hsel <= 1'b0;
        // Reads toggle the data lines so stale data cannot pass
        hwdata <= !w ? ~hwdata : (a == OFF_DEACT ? {19'h0, d[12:0]} : d);
        do @(posedge hclk); while (!hready && ++n < 64);
        if (n >= 64) hung <= 1'b1;
    endtask : xfer
endmodule : idw_sw_master

// ### tb/idw_deactivate_tb.sv
// Self-checking bench of the deactivate block
`timescale 1ns/1ps
module idw_deactivate_tb
    import idw_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hnonsec, hready, hreadyout, hresp, ack_control, hung;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, ctl;
    logic [63:0] int_active, int_group1, act, g, save;
    logic [127:0] swint_pending;
    logic rdp = 1'b0;
    logic [31:0] q[$];
    int n_errors = 0;
    int compares = 0;
    int seed = 32'h88fa;
    assign hready = hreadyout;
    idw_deactivate #(.NUM_INT(64), .HAS_SECURITY(1'b1)) i_idw_deactivate (.*);
    idw_sw_master i_idw_sw_master (.*);
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // ==========
    // Tasks
    task automatic finish_test;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] e);
        compares++;
        if (got !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, e);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns = 1'b0);
        i_idw_sw_master.xfer(a, 1'b1, d, ns);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ns = 1'b0);
        q.push_back(e);
        i_idw_sw_master.xfer(a, 1'b0, 32'h0, ns);
    endtask : rd
    task automatic deact(input logic [9:0] id, input logic [2:0] cpu, input logic ns);
        wr(OFF_DEACT, {19'h0, cpu, id}, ns);
        if ((ns ? ctl[1] : ctl[0]) && id < 64 && (!ns || g[id])) begin
            act[id] = 1'b0;
        end
    endtask : deact
    task automatic chk_act;
        for (int k = 0; k < 2; k++) begin
            rd(OFF_SET_ACT + 12'(4 * k), act[32 * k +: 32]);
        end
    endtask : chk_act
    task automatic wctl(input logic [2:0] v);
        ctl = v;
        wr(OFF_CTRL, {29'h0, v});
    endtask : wctl
    // ==========
    // Read monitor and hang guard
    always @(posedge hclk) begin
        if (hreadyout) begin
            if (rdp) check(hrdata, q.pop_front());
            rdp <= hsel && htrans[1] && !hwrite;
        end
    end
    always @(posedge hung) begin
        n_errors++;
        finish_test();
    end
    // ==========
    // Scenarios
    initial begin
        hresetn = 1'b0;
        ctl = 3'h0;
        act = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFF_CTRL, 32'h0);
        chk_act();
        wr(12'h400, $random(seed));
        rd(12'h400, 32'h0);
        g = {$random(seed), $random(seed)};
        for (int k = 0; k < 2; k++) begin
            wr(OFF_GROUP + 12'(4 * k), g[32 * k +: 32]);
            wr(OFF_SET_ACT + 12'(4 * k), 32'hffff_ffff);
        end
        act = '1;
        check(int_group1[31:0], g[31:0]);
        check(int_group1[63:32], g[63:32]);
        chk_act();
        wctl(3'h4);
        deact(10'd9, 3'h0, 1'b0);
        deact(10'd40, 3'h0, 1'b1);
        chk_act();
        wctl(3'h7);
        for (int i = 0; i < 8; i++) begin
            deact(10'((i * 23 + 5) % 64), 3'($random(seed)), i[0]);
        end
        chk_act();
        deact(10'd20, 3'h5, 1'b0);
        rd(OFF_LAST, 32'd20);
        deact(10'd2, 3'h5, 1'b0);
        rd(OFF_LAST, {19'h0, 3'h5, 10'd2});
        deact(SPURIOUS_ID, 3'h0, 1'b0);
        wctl(3'h1);
        deact(10'd50, 3'h0, 1'b1);
        chk_act();
        save = act;
        for (int k = 0; k < 2; k++) begin
            wr(OFF_CLR_ACT + 12'(4 * k), 32'hffff_ffff);
        end
        act = '0;
        chk_act();
        for (int k = 0; k < 2; k++) begin
            wr(OFF_SET_ACT + 12'(4 * k), save[32 * k +: 32]);
        end
        act = save;
        chk_act();
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            wr(OFF_SET_SWINT + 12'(4 * k), r);
            wr(OFF_CLR_SWINT + 12'(4 * k), r & 32'h0f0f_0f0f);
            @(posedge hclk);
            check(swint_pending[32 * k +: 32], r & 32'hf0f0_f0f0);
            wr(OFF_APR + 12'(4 * k), r);
            wr(OFF_NSAPR + 12'(4 * k), ~r);
            rd(OFF_APR + 12'(4 * k), r);
            rd(OFF_NSAPR + 12'(4 * k), ~r);
            rd(OFF_APR + 12'(4 * k), 32'h0, 1'b1);
        end
        repeat (2) @(posedge hclk);
        finish_test();
    end
endmodule : idw_deactivate_tb
